// [sim/fpio_pin_model.sv]
// outside circuitry on the four ports: resolves each pin level
`timescale 1ns/1ps
`default_nettype none
module fpio_pin_model (
	input wire fpio_pkg::fpio_pad_s padA, // timer port drive
	input wire fpio_pkg::fpio_pad_s padB, // second port drive
	input wire fpio_pkg::fpio_pad_s padC, // third port drive
	input wire fpio_pkg::fpio_pad_s padD, // fourth port drive
	input wire logic [7:0] extLevel, // level outside parts force
	output logic [7:0] pinA, // timer port pins
	output logic [7:0] pinB, // second port pins
	output logic [7:0] pinC, // third port pins
	output logic [7:0] pinD // fourth port pins
);
	// a driven pin shows the device level; a released one the outside
	// level, so a stale device value can never pass for a pin reading
	function automatic logic [7:0] res(fpio_pkg::fpio_pad_s p,
		logic [7:0] e);
		return (~p.oeN & p.out) | (p.oeN & e);
	endfunction
	// all four ports resolved the same way
	assign pinA = res(padA, extLevel);
	assign pinB = res(padB, extLevel);
	assign pinC = res(padC, extLevel);
	assign pinD = res(padD, extLevel);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the four-port parallel i/o block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdData;
	fpio_pkg::fpio_mode_e busMode = fpio_pkg::MODE_SINGLE;
	fpio_pkg::fpio_xbus_s xbus = '0;
	fpio_pkg::fpio_tmr_s tmr = '0;
	fpio_pkg::fpio_spi_s spi = '0;
	fpio_pkg::fpio_sci_s sci = '0;
	logic [7:0] extLevel = 8'h3C;
	logic [7:0] pinA, pinB, pinC, pinD;
	logic [7:0] levelA, levelC, levelD;
	fpio_pkg::fpio_pad_s padA, padB, padC, padD;
	int errCount = 0;
	int comparisons = 0;

	// 25 MHz core clock
	always #20 clk_sys = ~clk_sys;

	fpio_ports i_fpio_ports (.clk_sys(clk_sys), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .busMode(busMode),
		.xbus(xbus), .tmr(tmr), .spi(spi), .sci(sci), .pinInA(pinA),
		.pinInB(pinB), .pinInC(pinC), .pinInD(pinD), .padA(padA),
		.padB(padB), .padC(padC), .padD(padD), .levelA(levelA),
		.levelC(levelC), .levelD(levelD));

	fpio_pin_model i_fpio_pin_model (.padA(padA), .padB(padB),
		.padC(padC), .padD(padD), .extLevel(extLevel), .pinA(pinA),
		.pinB(pinB), .pinC(pinC), .pinD(pinD));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 chk(regRdData, exp);
	endtask

	// pads are registered and pin reads pass two sync flops
	task automatic settle();
		repeat (4) @(posedge clk_sys);
		#1;
	endtask

	task automatic t_reset();
		chk(padA.oeN, 8'h8F);
		chk(padA.out, 8'h00);
		chk(padB.oeN, 8'hFF);
		rd(fpio_pkg::OFS_CONTROL, 8'h00);
		rd(fpio_pkg::OFS_PULSE_CTL, 8'h00);
		chk(levelA, 8'h0C);
		$display("test reset done");
	endtask

	task automatic t_regs();
		wr(fpio_pkg::OFS_SERIAL_DIR, 8'hC3);
		rd(fpio_pkg::OFS_SERIAL_DIR, 8'hC3);
		wr(fpio_pkg::OFS_CONTROL, 8'hFF);
		rd(fpio_pkg::OFS_CONTROL, 8'h20);
		rd(8'h55, 8'h00);
		wr(fpio_pkg::OFS_CONTROL, 8'h00);
		wr(fpio_pkg::OFS_SERIAL_DIR, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_serial_pin_port_data();
		wr(fpio_pkg::OFS_SERIAL_DATA, 8'hA5);
		settle();
		chk(padD.oeN, 8'hFF);
		wr(fpio_pkg::OFS_SERIAL_DIR, 8'h0F);
		settle();
		chk(padD.oeN, 8'hF0);
		chk(padD.out & 8'h0F, 8'h05);
		chk(levelD, 8'h35);
		rd(fpio_pkg::OFS_SERIAL_DATA, 8'h35);
		// serial pins taken over: latch must not reach them
		@(posedge clk_sys);
		sci <= '{txEnable: 1'b1, txLevel: 1'b1, rxEnable: 1'b1};
		settle();
		chk(padD.oeN, 8'hF1);
		chk(padD.out & 8'h03, 8'h03);
		@(posedge clk_sys);
		sci <= '0;
		$display("test serial_pin_port_data done");
	endtask

	task automatic t_upper_port_data();
		wr(fpio_pkg::OFS_UPPER_DIR, 8'h0F);
		wr(fpio_pkg::OFS_UPPER_DATA, 8'h96);
		settle();
		chk(padB.oeN, 8'hF0);
		chk(padB.out & 8'h0F, 8'h06);
		wr(fpio_pkg::OFS_UPPER_DIR, 8'h00);
		$display("test upper_port_data done");
	endtask

	task automatic t_spi();
		wr(fpio_pkg::OFS_SERIAL_DIR, 8'hFF);
		spi <= '{enable: 1'b1, master: 1'b0, outExpect: 3'b000,
			outLevel: 3'b000};
		settle();
		chk(padD.oeN & 8'h3C, 8'h3C);
		@(posedge clk_sys);
		spi <= '{enable: 1'b1, master: 1'b1, outExpect: 3'b111,
			outLevel: 3'b000};
		settle();
		chk(padD.oeN & 8'h3C, 8'h00);
		wr(fpio_pkg::OFS_SERIAL_DIR, 8'hE3);
		settle();
		chk(padD.oeN & 8'h3C, 8'h1C);
		@(posedge clk_sys);
		spi <= '0;
		wr(fpio_pkg::OFS_SERIAL_DIR, 8'h00);
		$display("test spi done");
	endtask

	task automatic t_timer();
		wr(fpio_pkg::OFS_PULSE_CTL, 8'h08);
		settle();
		chk(padA.oeN & 8'h08, 8'h00);
		wr(fpio_pkg::OFS_PULSE_CTL, 8'h00);
		tmr <= '{ocEnable: 5'b00001, ocLevel: 5'b00001};
		settle();
		chk(padA.oeN & 8'h08, 8'h00);
		chk(padA.out & 8'h08, 8'h08);
		wr(fpio_pkg::OFS_PULSE_CTL, 8'h04);
		settle();
		chk(padA.oeN & 8'h08, 8'h08);
		@(posedge clk_sys);
		tmr <= '0;
		wr(fpio_pkg::OFS_PULSE_CTL, 8'h00);
		$display("test timer done");
	endtask

	task automatic t_bus();
		wr(fpio_pkg::OFS_THIRD_DIR, 8'hFF);
		wr(fpio_pkg::OFS_THIRD_DATA, 8'h81);
		settle();
		chk(padC.oeN, 8'h00);
		chk(padC.out, 8'h81);
		chk(levelC, 8'h81);
		@(posedge clk_sys);
		busMode <= fpio_pkg::MODE_EXPANDED;
		xbus <= '{addr: 16'h1234, wrData: 8'h5A, dataPhase: 1'b0,
			readNotWrite: 1'b1, addrStrobe: 1'b1};
		settle();
		chk(padB.out, 8'h12);
		chk(padB.oeN, 8'h00);
		chk(padC.out, 8'h34);
		chk(padD.oeN & 8'hC0, 8'h00);
		chk(padD.out & 8'hC0, 8'hC0);
		@(posedge clk_sys);
		xbus.dataPhase <= 1'b1;
		settle();
		chk(padC.oeN, 8'hFF);
		@(posedge clk_sys);
		xbus.readNotWrite <= 1'b0;
		settle();
		chk(padC.out, 8'h5A);
		chk(padC.oeN, 8'h00);
		wr(fpio_pkg::OFS_CONTROL, 8'h20);
		settle();
		chk(padC.oeN, 8'h5A);
		wr(fpio_pkg::OFS_CONTROL, 8'h00);
		// test mode lends the bus too; boot mode gives pins back
		busMode <= fpio_pkg::MODE_TEST;
		settle();
		chk(padB.oeN, 8'h00);
		chk(padD.out & 8'hC0, 8'h40);
		@(posedge clk_sys);
		busMode <= fpio_pkg::MODE_BOOT;
		settle();
		chk(padB.oeN, 8'hFF);
		chk(padC.out, 8'h81);
		chk(padD.oeN & 8'hC0, 8'hC0);
		@(posedge clk_sys);
		busMode <= fpio_pkg::MODE_SINGLE;
		xbus <= '0;
		$display("test bus done");
	endtask

	// verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog: the run needs well under 1000 cycles
	initial begin
		#200us;
		errCount++;
		results();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		settle();
		t_reset();
		t_regs();
		t_serial_pin_port_data();
		t_upper_port_data();
		t_spi();
		t_timer();
		t_bus();
		results();
	end
endmodule
`default_nettype wire

// [verilog/fpio_pad_drv.sv]
// registered pad driver for one 8-bit port, optional open drain
`timescale 1ns/1ps
`default_nettype none
module fpio_pad_drv #(
	parameter logic [7:0] RST_OEN = 8'hFF
) (
	input wire logic clk_sys, // core clock
	input wire logic reset, // async, active high
	input wire logic [7:0] drive, // level wanted on each pin
	input wire logic [7:0] enable, // pin owned as output
	input wire logic openDrain, // release pins driven high
	output var fpio_pkg::fpio_pad_s pad // registered pin controls
);
	fpio_pkg::fpio_pad_s st_r, st_nxt;

	// open drain only pulls low; a high level floats the pin
	always_comb begin
		st_nxt.out = drive;
		st_nxt.oeN = ~(enable & ~({8{openDrain}} & drive));
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r <= '{out: 8'h00, oeN: RST_OEN};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pad = st_r;
endmodule
`default_nettype wire

// [verilog/fpio_pkg.sv]
// constants and carrier types of the four-port parallel i/o block
package fpio_pkg;
	// register offsets
	localparam logic [7:0] OFS_TIMER_DATA = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h02;
	localparam logic [7:0] OFS_THIRD_DATA = 8'h03;
	localparam logic [7:0] OFS_UPPER_DATA = 8'h04;
	localparam logic [7:0] OFS_UPPER_DIR = 8'h06;
	localparam logic [7:0] OFS_THIRD_DIR = 8'h07;
	localparam logic [7:0] OFS_SERIAL_DATA = 8'h08;
	localparam logic [7:0] OFS_SERIAL_DIR = 8'h09;
	localparam logic [7:0] OFS_PULSE_CTL = 8'h26;
	// reset values and write masks
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CONTROL_WMASK = 8'h20;
	localparam logic [7:0] PAD_RELEASED = 8'hFF;
	localparam logic [7:0] TIMER_PAD_RESET = 8'h8F;
	// field positions
	localparam int PCTL_DIR7 = 7;
	localparam int PCTL_DIR3 = 3;
	localparam int PCTL_SHARE = 2;
	localparam int CTL_OPEN_DRAIN = 5;
	localparam int SD_RXD = 0;
	localparam int SD_TXD = 1;
	localparam int SD_SPI_LO = 2;
	localparam int SD_SLAVE_SEL = 5;
	localparam int SD_STROBE = 6;
	localparam int SD_RDWR = 7;
	localparam int TP_SHARED = 3;
	// fixed timer-port directions
	localparam logic [7:0] TP_OUT_ONLY = 8'h70;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_EXPANDED,
		MODE_BOOT,
		MODE_TEST
	} fpio_mode_e;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oeN;
	} fpio_pad_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wrData;
		logic dataPhase;
		logic readNotWrite;
		logic addrStrobe;
	} fpio_xbus_s;

	typedef struct packed {
		logic [7:3] ocEnable;
		logic [7:3] ocLevel;
	} fpio_tmr_s;

	typedef struct packed {
		logic enable;
		logic master;
		logic [2:0] outExpect;
		logic [2:0] outLevel;
	} fpio_spi_s;

	typedef struct packed {
		logic txEnable;
		logic txLevel;
		logic rxEnable;
	} fpio_sci_s;
endpackage

// [verilog/fpio_ports.sv]
// four-port parallel i/o: data latches, directions and pin ownership
// Summary of operation
// - four 8-bit ports; second, third and fourth port pins general i/o in single-chip and boot
// - expanded mode: second port drives address bits 15 to 8
// - expanded mode: third port muxes address/data, data direction by r/w
// - timer port: fixed capture inputs, compare outputs, shared pins
// - second port direction bit: 0 input only, 1 output
// - fourth port reads: inputs give pin, outputs give driver input
// - fourth port writes latched; reach pin only as general output
// - fourth port direction bit: 0 input, 1 output
// - expanded/test: fourth port bits 6,7 drive strobe and r/w
// - spi enabled: bit 5 slave select input; slave ignores its direction
// - spi master: bit 5 direction 0 fault input, 1 general output
// - spi expecting inputs on bits 2-4 forces them to inputs
// - spi expecting outputs on bits 2-4 drives only with direction 1
// - timer bit 3 direction: 0 input, 1 output; compare overrides
// - share select: 0 fifth compare, 1 fourth capture on shared pin
// - open-drain select: third port push-pull at 0, open drain at 1
// - control register: only open-drain select works, cleared by reset
`timescale 1ns/1ps
`default_nettype none
module fpio_ports (
	input wire logic clk_sys, // 25 MHz core clock
	input wire logic reset, // async, active high
	input wire logic [7:0] regAddr, // register offset
	input wire logic [7:0] regWrData, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [7:0] regRdData, // read data, cycle after strobe
	input wire fpio_pkg::fpio_mode_e busMode, // operating mode
	input wire fpio_pkg::fpio_xbus_s xbus, // expansion bus request
	input wire fpio_pkg::fpio_tmr_s tmr, // timer compare drive
	input wire fpio_pkg::fpio_spi_s spi, // spi pin demands
	input wire fpio_pkg::fpio_sci_s sci, // sci pin demands
	input wire logic [7:0] pinInA, // timer port pin levels
	input wire logic [7:0] pinInB, // second port pin levels
	input wire logic [7:0] pinInC, // third port pin levels
	input wire logic [7:0] pinInD, // fourth port pin levels
	output var fpio_pkg::fpio_pad_s padA, // timer port drive
	output var fpio_pkg::fpio_pad_s padB, // second port drive
	output var fpio_pkg::fpio_pad_s padC, // third port drive
	output var fpio_pkg::fpio_pad_s padD, // fourth port drive
	output logic [7:0] levelA, // synced timer pins, for captures
	output logic [7:0] levelC, // synced third port, bus read data
	output logic [7:0] levelD // synced fourth port, for serial
);
	typedef struct packed {
		logic [7:0] tmrLatch;
		logic [7:0] upLatch;
		logic [7:0] upDir;
		logic [7:0] thLatch;
		logic [7:0] thDir;
		logic [7:0] srLatch;
		logic [7:0] srDir;
		logic [7:0] pulseCtl;
		logic [7:0] ioCtl;
		logic [7:0] rdData;
	} fpio_state_s;

	fpio_state_s st_r, st_nxt;
	logic [31:0] pinSync;
	logic [7:0] lvlA, lvlB, lvlC, lvlD;
	logic [7:0] drvA, drvB, drvC, drvD;
	logic [7:0] enA, enB, enC, enD;
	logic [7:0] ocOwn;
	logic busOn;
	logic openDrain;

	// pins come from outside the clock domain
	fpio_sync #(
		.W(32)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.asyncIn({pinInD, pinInC, pinInB, pinInA}),
		.syncOut(pinSync)
	);

	assign lvlA = pinSync[7:0];
	assign lvlB = pinSync[15:8];
	assign lvlC = pinSync[23:16];
	assign lvlD = pinSync[31:24];
	assign levelA = lvlA;
	assign levelC = lvlC;
	assign levelD = lvlD;

	// inputs read the pin, outputs read their own driver input
	function automatic logic [7:0] pinView(
		input logic [7:0] drv,
		input logic [7:0] en,
		input logic [7:0] lvl
	);
		return (drv & en) | (lvl & ~en);
	endfunction

	// expanded and test modes lend ports to the memory bus
	assign busOn = (busMode == fpio_pkg::MODE_EXPANDED) ||
		(busMode == fpio_pkg::MODE_TEST);
	assign openDrain = st_r.ioCtl[fpio_pkg::CTL_OPEN_DRAIN];

	// timer port ownership
	always_comb begin
		ocOwn = {tmr.ocEnable, 3'b000};
		// shared pin belongs to the fifth compare only when selected
		if (st_r.pulseCtl[fpio_pkg::PCTL_SHARE]) begin
			ocOwn[fpio_pkg::TP_SHARED] = 1'b0;
		end
		enA = fpio_pkg::TP_OUT_ONLY;
		enA[7] = st_r.pulseCtl[fpio_pkg::PCTL_DIR7];
		enA[3] = st_r.pulseCtl[fpio_pkg::PCTL_DIR3];
		enA = enA | ocOwn;
		drvA = (st_r.tmrLatch & ~ocOwn) | ({tmr.ocLevel, 3'b000} & ocOwn);
	end

	// second and third ports: general i/o or expansion bus
	always_comb begin
		if (busOn) begin
			drvB = xbus.addr[15:8];
			enB = 8'hFF;
			if (xbus.dataPhase) begin
				drvC = xbus.wrData;
				enC = xbus.readNotWrite ? 8'h00 : 8'hFF;
			end else begin
				drvC = xbus.addr[7:0];
				enC = 8'hFF;
			end
		end else begin
			drvB = st_r.upLatch;
			enB = st_r.upDir;
			drvC = st_r.thLatch;
			enC = st_r.thDir;
		end
	end

	// fourth port: latch and direction, then peripherals take pins
	always_comb begin
		drvD = st_r.srLatch;
		enD = st_r.srDir;
		if (sci.rxEnable) begin
			enD[fpio_pkg::SD_RXD] = 1'b0;
		end
		if (sci.txEnable) begin
			drvD[fpio_pkg::SD_TXD] = sci.txLevel;
			enD[fpio_pkg::SD_TXD] = 1'b1;
		end
		if (spi.enable) begin
			for (int i = 0; i < 3; i++) begin
				if (spi.outExpect[i]) begin
					drvD[fpio_pkg::SD_SPI_LO + i] = spi.outLevel[i];
					enD[fpio_pkg::SD_SPI_LO + i] =
						st_r.srDir[fpio_pkg::SD_SPI_LO + i];
				end else begin
					enD[fpio_pkg::SD_SPI_LO + i] = 1'b0;
				end
			end
			// master keeps the direction bit; slave always listens
			if (!spi.master) begin
				enD[fpio_pkg::SD_SLAVE_SEL] = 1'b0;
			end else begin
				enD[fpio_pkg::SD_SLAVE_SEL] =
					st_r.srDir[fpio_pkg::SD_SLAVE_SEL];
			end
		end
		if (busOn) begin
			drvD[fpio_pkg::SD_STROBE] = xbus.addrStrobe;
			drvD[fpio_pkg::SD_RDWR] = xbus.readNotWrite;
			enD[fpio_pkg::SD_STROBE] = 1'b1;
			enD[fpio_pkg::SD_RDWR] = 1'b1;
		end
	end

	// register writes and one-cycle read answer
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdData = 8'h00;
		if (regWr) begin
			unique case (regAddr)
				fpio_pkg::OFS_TIMER_DATA: st_nxt.tmrLatch = regWrData;
				fpio_pkg::OFS_UPPER_DATA: st_nxt.upLatch = regWrData;
				fpio_pkg::OFS_UPPER_DIR: st_nxt.upDir = regWrData;
				fpio_pkg::OFS_THIRD_DATA: st_nxt.thLatch = regWrData;
				fpio_pkg::OFS_THIRD_DIR: st_nxt.thDir = regWrData;
				fpio_pkg::OFS_SERIAL_DATA: st_nxt.srLatch = regWrData;
				fpio_pkg::OFS_SERIAL_DIR: st_nxt.srDir = regWrData;
				fpio_pkg::OFS_PULSE_CTL: st_nxt.pulseCtl = regWrData;
				fpio_pkg::OFS_CONTROL: begin
					st_nxt.ioCtl = regWrData & fpio_pkg::CONTROL_WMASK;
				end
				default: st_nxt.tmrLatch = st_r.tmrLatch;
			endcase
		end
		// unmapped offsets read as zero
		if (regRd) begin
			unique case (regAddr)
				fpio_pkg::OFS_TIMER_DATA: st_nxt.rdData = pinView(drvA, enA, lvlA);
				fpio_pkg::OFS_UPPER_DATA: st_nxt.rdData = pinView(drvB, enB, lvlB);
				fpio_pkg::OFS_UPPER_DIR: st_nxt.rdData = st_r.upDir;
				fpio_pkg::OFS_THIRD_DATA: st_nxt.rdData = pinView(drvC, enC, lvlC);
				fpio_pkg::OFS_THIRD_DIR: st_nxt.rdData = st_r.thDir;
				fpio_pkg::OFS_SERIAL_DATA: begin
					st_nxt.rdData = pinView(drvD, enD, lvlD);
				end
				fpio_pkg::OFS_SERIAL_DIR: st_nxt.rdData = st_r.srDir;
				fpio_pkg::OFS_PULSE_CTL: st_nxt.rdData = st_r.pulseCtl;
				fpio_pkg::OFS_CONTROL: st_nxt.rdData = st_r.ioCtl;
				default: st_nxt.rdData = 8'h00;
			endcase
		end
	end

	// all control clears on reset: no open drain, all direction bits input; timer bits 6..4 stay fixed outputs
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r <= '{default: fpio_pkg::REG_RESET};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdData = st_r.rdData;

	// timer bits 6..4 hold low through reset, the rest float
	fpio_pad_drv #(
		.RST_OEN(fpio_pkg::TIMER_PAD_RESET)
	) u_padA (
		.clk_sys(clk_sys),
		.reset(reset),
		.drive(drvA),
		.enable(enA),
		.openDrain(1'b0),
		.pad(padA)
	);

	fpio_pad_drv #(
		.RST_OEN(fpio_pkg::PAD_RELEASED)
	) u_padB (
		.clk_sys(clk_sys),
		.reset(reset),
		.drive(drvB),
		.enable(enB),
		.openDrain(1'b0),
		.pad(padB)
	);

	// open drain applies to all eight third-port pins in every mode
	fpio_pad_drv #(
		.RST_OEN(fpio_pkg::PAD_RELEASED)
	) u_padC (
		.clk_sys(clk_sys),
		.reset(reset),
		.drive(drvC),
		.enable(enC),
		.openDrain(openDrain),
		.pad(padC)
	);

	fpio_pad_drv #(
		.RST_OEN(fpio_pkg::PAD_RELEASED)
	) u_padD (
		.clk_sys(clk_sys),
		.reset(reset),
		.drive(drvD),
		.enable(enD),
		.openDrain(1'b0),
		.pad(padD)
	);

	// checks on pin ownership and register read answers, one cycle after the cause
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence sShareSelCompare;
		regWr && regAddr == fpio_pkg::OFS_PULSE_CTL &&
			!regWrData[fpio_pkg::PCTL_SHARE];
	endsequence

	sequence sReadSerialDir;
		regRd && regAddr == fpio_pkg::OFS_SERIAL_DIR;
	endsequence

	a_upper_addr_drive: assert property (
		busOn |=> padB.oeN == 8'h00 && padB.out == $past(xbus.addr[15:8]))
		else $error("second port not driving upper address");

	a_upper_dir_gpio: assert property (
		!busOn |=> padB.oeN == ~$past(st_r.upDir))
		else $error("second port direction not followed");

	a_third_data_read: assert property (
		busOn && xbus.dataPhase && xbus.readNotWrite |=> padC.oeN == 8'hFF)
		else $error("third port drives during bus read");

	// open drain holds in bus modes too, so no driven pin may be high
	a_open_drain_high: assert property (
		openDrain |=> (~padC.oeN & padC.out) == 8'h00)
		else $error("open drain pin driven high");

	a_bus_ctl_pins: assert property (
		busOn |=> padD.oeN[7:6] == 2'b00 &&
			padD.out[6] == $past(xbus.addrStrobe) &&
			padD.out[7] == $past(xbus.readNotWrite))
		else $error("strobe or r/w pin not owned by bus");

	a_slave_sel_in: assert property (
		spi.enable && !spi.master |=> padD.oeN[fpio_pkg::SD_SLAVE_SEL])
		else $error("slave select driven in slave mode");

	a_spi_in_force: assert property (
		spi.enable && !spi.outExpect[0] |=> padD.oeN[fpio_pkg::SD_SPI_LO])
		else $error("spi input pin driven");

	a_share_oc5_pin: assert property (
		sShareSelCompare ##1 tmr.ocEnable[3] |=>
			!padA.oeN[3] && padA.out[3] == $past(tmr.ocLevel[3]))
		else $error("fifth compare not on shared pin");

	a_read_dir_reg: assert property (
		sReadSerialDir |=> regRdData == $past(st_r.srDir) ##1
			regRdData == 8'h00 || $past(regRd))
		else $error("direction read answer wrong");

	a_capture_inputs: assert property (
		1'b1 |=> padA.oeN[2:0] == 3'b111)
		else $error("capture pin driven");
endmodule
`default_nettype wire

// [verilog/fpio_sync.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module fpio_sync #(
	parameter int W = 8
) (
	input wire logic clk_sys, // core clock
	input wire logic reset, // async, active high
	input wire logic [W-1:0] asyncIn, // raw pin levels
	output logic [W-1:0] syncOut // levels after two flops
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fpio_sync_s;
	fpio_sync_s st_r, st_nxt;

	// first stage feeds only the second
	always_comb begin
		st_nxt.s1 = asyncIn;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign syncOut = st_r.s2;
endmodule
`default_nettype wire
